// file: fpc_top.sv
/*
 Fast pulse counter with its counter element, status flags, interrupt tracking
 and preset-driven output pattern, reached over a classic Wishbone slave.
 Assumes a single 50 MHz clock and a master that holds each request until ack.
*/
`timescale 1ns/1ps
module fpc_top
	import fpc_pkg::*;
(
	input wire logic clk_i, // System clock, 50 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [5:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire logic [3:0] pin_i, // Counter input pins.
	output logic [15:0] out_o, // Preset-driven output pattern.
	output logic irq_o // Counter interrupt waiting for service.
);

	logic ack_q;
	logic [31:0] rdat_q;
	logic [15:0] stat_q;
	logic signed [15:0] img_pre_q;
	logic signed [15:0] img_acc_q;
	logic signed [15:0] low_img_q;
	logic [3:0] mode_q;
	logic [15:0] src_q;
	logic [15:0] mask_q;
	logic signed [15:0] acc_q;
	logic signed [15:0] acc_d;
	logic signed [15:0] hw_pre_q;
	logic signed [15:0] hw_low_q;
	logic [15:0] out_q;
	logic err_q;
	logic [3:0] cause_q;
	fpc_state_t st_q;
	fpc_cnt_ev_t ev;
	fpc_ops_t ops;
	logic wr;
	logic [3:0] idx;
	logic [15:0] wmask;
	logic [15:0] wdat;
	logic up_mode;
	logic first_cfg;
	logic run;
	logic wrap_hi;
	logic wrap_lo;
	logic hit_hi;
	logic hit_lo;
	logic hp_now;
	logic lp_now;
	logic irq_ev;
	logic pre_ok;
	logic ua_wr;
	logic unl_wr;

	fpc_input u_input (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pin_i),
		.mode_i(mode_q),
		.ev_o(ev)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode: one write per request, taken in the cycle before its acknowledge.
	assign idx = wb_adr_i[5:2];
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat = wb_dat_i[15:0];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign out_o = out_q;
	assign irq_o = stat_q[FPC_B_PE];

	// Control write split into one-shot operations.
	always_comb
	begin
		ops = '0;
		if (wr && idx == FPC_IDX_CTRL && wb_sel_i[0])
		begin
			ops.eval = wdat[FPC_C_EVAL];
			ops.rung = wdat[FPC_C_RUNG];
			ops.clear = wdat[FPC_C_CLEAR];
			ops.load = wdat[FPC_C_LOAD];
			ops.irq_en = wdat[FPC_C_IRQEN];
			ops.irq_dis = wdat[FPC_C_IRQDIS];
			ops.ld_pre = wdat[FPC_C_LDPRE];
			ops.isr = wdat[FPC_C_ISR];
		end
	end

	// Status word writes: refresh request and unlatching of sticky flags.
	assign ua_wr = wr && idx == FPC_IDX_STATUS && wb_sel_i[1] && wdat[FPC_B_UA];
	assign unl_wr = wr && idx == FPC_IDX_STATUS;
	assign up_mode = mode_q <= FPC_MODE_UP_LAST;
	assign first_cfg = st_q == FPC_ST_UNCONF && ops.eval && ops.rung;
	assign run = st_q == FPC_ST_CONF && stat_q[FPC_B_CU] && !ev.hold; // R20
	assign pre_ok = img_pre_q >= FPC_HP_MIN; // R24

	////////////////////////////////////////////////////////////////////////////
	// Next hardware accumulator: clear, load, external reset, then counting.
	always_comb
	begin
		acc_d = acc_q;
		wrap_hi = 1'b0;
		wrap_lo = 1'b0;
		if (ops.clear)
			acc_d = 16'sh0000; // R18
		else if (ops.load || first_cfg)
			acc_d = img_acc_q; // R19
		else if (run && ev.zero)
			acc_d = 16'sh0000;
		else if (run && ev.up)
		begin
			acc_d = acc_q + 16'sh0001; // R21 R25
			wrap_hi = acc_q == FPC_ACC_MAX && !up_mode; // R7
		end
		else if (run && ev.down && !up_mode)
		begin
			acc_d = acc_q - 16'sh0001; // R21 R25
			wrap_lo = acc_q == FPC_ACC_MIN; // R8
		end
	end

	// Preset comparisons; bidirectional events fire on entry to the region.
	assign hp_now = acc_q >= hw_pre_q;
	assign lp_now = acc_q <= hw_low_q;
	assign hit_hi = st_q == FPC_ST_CONF && hp_now && (up_mode || !stat_q[FPC_B_HP]);
	assign hit_lo = st_q == FPC_ST_CONF && !up_mode && lp_now && !stat_q[FPC_B_LP];
	assign irq_ev = stat_q[FPC_B_IE] && (hit_hi || hit_lo || wrap_hi || wrap_lo); // R17

	////////////////////////////////////////////////////////////////////////////
	// Configuration life cycle: running from the first true configure.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_q <= FPC_ST_UNCONF;
		else
			case (st_q)
				FPC_ST_UNCONF: if (first_cfg) st_q <= FPC_ST_CONF; // R20
				FPC_ST_CONF: st_q <= FPC_ST_CONF;
				default: st_q <= FPC_ST_UNCONF;
			endcase
	end

	// Hardware accumulator, cleared after an up-mode high preset hit.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			acc_q <= 16'sh0000;
		else if (up_mode && hit_hi && !ops.clear && !ops.load)
			acc_q <= 16'sh0000; // R23
		else
			acc_q <= acc_d;
	end

	// Hardware presets: loaded at first configure, by the preset load op, and
	// the high one in up modes after each hit; an out-of-range high preset is refused.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hw_pre_q <= FPC_ACC_MAX;
			hw_low_q <= FPC_ACC_MIN;
			err_q <= 1'b0;
		end
		else
		begin
			if (first_cfg || ops.ld_pre || (up_mode && hit_hi))
			begin
				if (pre_ok)
					hw_pre_q <= img_pre_q; // R23 R24
				err_q <= !pre_ok; // R24
			end
			if (first_cfg || ops.ld_pre)
				hw_low_q <= low_img_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Image words and the configuration registers written by software.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			img_pre_q <= 16'sh0000;
			img_acc_q <= 16'sh0000;
			low_img_q <= 16'sh0000;
			mode_q <= FPC_MODE_RST;
			src_q <= 16'h0000;
			mask_q <= 16'h0000;
		end
		else
		begin
			if (wr && idx == FPC_IDX_PRESET)
				img_pre_q <= (img_pre_q & ~wmask) | (wdat & wmask);
			if (ops.clear)
				img_acc_q <= 16'sh0000; // R18
			else if (ops.load)
				img_acc_q <= img_acc_q; // R19
			else if (ua_wr || (ops.eval && ops.rung && st_q == FPC_ST_CONF))
				img_acc_q <= acc_q; // R9
			else if (wr && idx == FPC_IDX_ACC)
				img_acc_q <= (img_acc_q & ~wmask) | (wdat & wmask);
			if (wr && idx == FPC_IDX_LOWPRE)
				low_img_q <= (low_img_q & ~wmask) | (wdat & wmask);
			if (wr && idx == FPC_IDX_MODE && wb_sel_i[0] && st_q == FPC_ST_UNCONF)
				mode_q <= wdat[3:0];
			if (wr && idx == FPC_IDX_SRC)
				src_q <= (src_q & ~wmask) | (wdat & wmask);
			if (wr && idx == FPC_IDX_MASK)
				mask_q <= (mask_q & ~wmask) | (wdat & wmask);
		end
	end

	// Output pattern refreshed at once whenever a preset is reached.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			out_q <= 16'h0000;
		else if (hit_hi || hit_lo)
			out_q <= (out_q & ~mask_q) | (src_q & mask_q); // R22
	end

	// Cause of the interrupt now waiting, handed to the status word at service.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cause_q <= 4'h0;
		else if (irq_ev && !stat_q[FPC_B_PE])
			cause_q <= {wrap_hi, wrap_lo & ~wrap_hi, hit_hi & ~wrap_hi & ~wrap_lo,
				hit_lo & ~hit_hi & ~wrap_hi & ~wrap_lo}; // R12 R13
	end

	////////////////////////////////////////////////////////////////////////////
	// Status word; clears are applied first so that a same-cycle set wins, except bit 1 (disable beats enable) and bit 2 (a clear or load blocks the set).
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stat_q <= FPC_STATUS_RST; // R1
		else
		begin
			if (first_cfg)
			begin
				stat_q[FPC_B_CU] <= 1'b0; // R2
				stat_q[FPC_B_CD] <= 1'b0;
				stat_q[FPC_B_IV:FPC_B_PE] <= 5'h00;
				stat_q[FPC_B_IE] <= 1'b1;
				if (wr && wb_sel_i[1])
					stat_q[FPC_B_HP:FPC_B_LP] <= stat_q[FPC_B_HP:FPC_B_LP]; // R10
			end
			if (unl_wr && wb_sel_i[1])
			begin
				if (!wdat[FPC_B_DN]) stat_q[FPC_B_DN] <= 1'b0; // R5
				if (!wdat[FPC_B_OV]) stat_q[FPC_B_OV] <= 1'b0; // R6
				if (!wdat[FPC_B_UN]) stat_q[FPC_B_UN] <= 1'b0; // R8
				if (st_q == FPC_ST_UNCONF && !up_mode)
					stat_q[FPC_B_HP:FPC_B_LP] <= wdat[FPC_B_HP:FPC_B_LP]; // R10
			end
			if (unl_wr && wb_sel_i[0] && !wdat[FPC_B_LS])
				stat_q[FPC_B_LS] <= 1'b0; // R15
			if (ops.clear || ops.load)
			begin
				stat_q[FPC_B_DN:FPC_B_UN] <= 3'h0; // R5 R6 R7
				stat_q[FPC_B_PE:FPC_B_LS] <= 2'h0; // R14 R15
			end
			if (ops.eval)
			begin
				stat_q[FPC_B_CU] <= ops.rung; // R3
				stat_q[FPC_B_CD] <= ops.rung && !up_mode; // R4
			end
			if (ops.irq_en)
				stat_q[FPC_B_IE] <= 1'b1; // R16
			if (ops.irq_dis)
				stat_q[FPC_B_IE] <= 1'b0; // R16
			if (ops.isr && stat_q[FPC_B_PE])
			begin
				stat_q[FPC_B_IV:FPC_B_IL] <= cause_q; // R12 R13
				stat_q[FPC_B_PE] <= 1'b0; // R14
			end
			stat_q[FPC_B_UA] <= 1'b0;
			stat_q[0] <= 1'b0;
			if (st_q == FPC_ST_CONF && !up_mode)
			begin
				stat_q[FPC_B_HP] <= hp_now; // R10
				stat_q[FPC_B_LP] <= lp_now; // R11
			end
			if (up_mode && hit_hi)
			begin
				stat_q[FPC_B_DN] <= 1'b1; // R5
				if (stat_q[FPC_B_DN])
					stat_q[FPC_B_OV] <= 1'b1; // R6
			end
			if (wrap_hi)
				stat_q[FPC_B_OV] <= 1'b1; // R7
			if (wrap_lo)
				stat_q[FPC_B_UN] <= 1'b1; // R8
			if (irq_ev)
			begin
				stat_q[FPC_B_PE] <= 1'b1; // R14 R17
				if (stat_q[FPC_B_PE] && !(ops.isr || ops.clear || ops.load))
					stat_q[FPC_B_LS] <= 1'b1; // R15
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wishbone answer: ack one cycle after the request, data registered with it.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
			case (idx)
				FPC_IDX_STATUS: rdat_q <= {16'h0000, stat_q};
				FPC_IDX_PRESET: rdat_q <= {16'h0000, img_pre_q};
				FPC_IDX_ACC: rdat_q <= {16'h0000, img_acc_q};
				FPC_IDX_CTRL: rdat_q <= {31'h0000_0000, stat_q[FPC_B_CU]};
				FPC_IDX_MODE: rdat_q <= {28'h000_0000, mode_q};
				FPC_IDX_LOWPRE: rdat_q <= {16'h0000, low_img_q};
				FPC_IDX_SRC: rdat_q <= {16'h0000, src_q};
				FPC_IDX_MASK: rdat_q <= {16'h0000, mask_q};
				FPC_IDX_INFO: rdat_q <= {16'h0000, err_q, 7'h00, err_q ? FPC_ERR_CODE : 8'h00};
				FPC_IDX_HWACC: rdat_q <= {16'h0000, acc_q};
				default: rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks on the counter, the flags and the interrupt tracking.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_cfg_clears_flags: assert property (first_cfg |=> !stat_q[FPC_B_PE]
		&& stat_q[FPC_B_IE] && stat_q[FPC_B_CU]) // R2
		else $error("First configure did not set up the status word.");
	a_up_enable_rung: assert property (ops.eval |=> stat_q[FPC_B_CU] == $past(ops.rung)) // R3
		else $error("Up-count enable does not follow the rung.");
	a_down_enable_mode: assert property (up_mode |-> !stat_q[FPC_B_CD]) // R4
		else $error("Down-count enable set in an up mode.");
	a_wrap_high_flag: assert property (wrap_hi && !ops.clear |=> stat_q[FPC_B_OV]
		&& acc_q == FPC_ACC_MIN) // R7
		else $error("Wrap from the top did not set its flag.");
	a_wrap_low_flag: assert property (wrap_lo |=> stat_q[FPC_B_UN]
		&& acc_q == FPC_ACC_MAX) // R8
		else $error("Wrap from the bottom did not set its flag.");
	a_clear_zeroes: assert property (ops.clear |=> acc_q == 16'sh0000
		&& img_acc_q == 16'sh0000) // R18
		else $error("Clear left a nonzero accumulator.");
	a_load_value: assert property (ops.load && !ops.clear |=> img_acc_q == $past(img_acc_q)
		&& (acc_q == $past(img_acc_q) || acc_q == 16'sh0000)) // R19
		else $error("Load did not copy the supplied value.");
	a_hold_stops: assert property (st_q == FPC_ST_CONF && !stat_q[FPC_B_CU]
		&& !ops.clear && !ops.load |=> acc_q == $past(acc_q)) // R20
		else $error("Accumulator moved while counting was inhibited.");
	a_lost_on_pending: assert property (irq_ev && stat_q[FPC_B_PE]
		&& !ops.isr && !ops.clear && !ops.load |=> stat_q[FPC_B_LS]) // R15
		else $error("Second interrupt while pending was not recorded.");
	a_pend_follows_ev: assert property (irq_ev |=> stat_q[FPC_B_PE] && irq_o) // R14 R17
		else $error("Interrupt event did not raise pending.");
	a_up_reload: assert property (up_mode && hit_hi && !ops.clear && !ops.load
		|=> acc_q == 16'sh0000 && stat_q[FPC_B_DN]) // R5 R23
		else $error("Up-mode preset hit did not clear and latch.");
	a_preset_range: assert property (hw_pre_q >= FPC_HP_MIN) // R24
		else $error("Hardware high preset outside its range.");
	a_bus_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle.");

	c_wrap_high: cover property (wrap_hi);
	c_lost_irq: cover property (irq_ev && stat_q[FPC_B_PE]);
	c_up_hit: cover property (up_mode && hit_hi ##1 up_mode && stat_q[FPC_B_DN]);
	c_isr_start: cover property (ops.isr && stat_q[FPC_B_PE]);

endmodule

// file: fpc_pkg.sv
/*
 Shared constants and types of the fast pulse counter: register indices, status
 bit positions, control bits, mode codes, limits and the packed carriers.
 Assumes a 32-bit classic Wishbone bus with byte addresses and one word per index.
*/
// Operation
// R1: Counter element is status word with 15 flags, signed preset and accumulator.
// R2: First configure clears status bits 3-7, 14, 15 and sets bit 1.
// R3: Bit 15 follows the configure rung; software cannot write it.
// R4: Bit 14 follows the configure rung in modes 3-8; not writable.
// R5: Up modes: bit 13 latches on high preset; cleared by unlatch, load, clear.
// R6: Up modes: bit 12 sets when high preset reached with bit 13 set.
// R7: Bidirectional: bit 12 sets on wrap from 32767 to -32768.
// R8: Bidirectional: bit 11 sets on wrap from -32768 to 32767.
// R9: Writing bit 10 or a true configure copies hardware into image accumulator.
// R10: Bidirectional: bit 9 shows accumulator at or above high preset.
// R11: Bidirectional: bit 8 shows accumulator at or below low preset.
// R12: Routine start by wrap sets bit 7 or 6, clears other causes.
// R13: Routine start by preset sets bit 5 or 4, clears other causes.
// R14: Bit 3 marks waiting interrupt; cleared at routine start, load or clear.
// R15: Bit 2 sets when an interrupt arrives while bit 3 set.
// R16: Bit 1 set by enable op, cleared by disable op only.
// R17: While enabled, preset, wrap high or wrap low events raise the interrupt.
// R18: Clear op zeroes hardware and image accumulators.
// R19: Load op writes supplied value to hardware and image accumulators.
// R20: Configure applies settings; counting allowed only while its rung is true.
// R21: Hardware accumulator counts on external input edges, independent of software.
// R22: On preset reached outputs update from source pattern under mask.
// R23: Up modes clear accumulator and reload preset on reach; bidirectional keep them.
// R24: Hardware high preset accepted only in 1..32767, else error 37H.
// R25: Hardware accumulator is 16-bit two's complement and wraps at both ends.
package fpc_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [3:0] FPC_IDX_STATUS = 4'h0;
	localparam logic [3:0] FPC_IDX_PRESET = 4'h1;
	localparam logic [3:0] FPC_IDX_ACC = 4'h2;
	localparam logic [3:0] FPC_IDX_CTRL = 4'h3;
	localparam logic [3:0] FPC_IDX_MODE = 4'h4;
	localparam logic [3:0] FPC_IDX_LOWPRE = 4'h5;
	localparam logic [3:0] FPC_IDX_SRC = 4'h6;
	localparam logic [3:0] FPC_IDX_MASK = 4'h7;
	localparam logic [3:0] FPC_IDX_INFO = 4'h8;
	localparam logic [3:0] FPC_IDX_HWACC = 4'h9;

	// Status word bit positions.
	localparam int FPC_B_CU = 15;
	localparam int FPC_B_CD = 14;
	localparam int FPC_B_DN = 13;
	localparam int FPC_B_OV = 12;
	localparam int FPC_B_UN = 11;
	localparam int FPC_B_UA = 10;
	localparam int FPC_B_HP = 9;
	localparam int FPC_B_LP = 8;
	localparam int FPC_B_IV = 7;
	localparam int FPC_B_IN = 6;
	localparam int FPC_B_IH = 5;
	localparam int FPC_B_IL = 4;
	localparam int FPC_B_PE = 3;
	localparam int FPC_B_LS = 2;
	localparam int FPC_B_IE = 1;
	localparam logic [15:0] FPC_STATUS_RST = 16'h0000;

	// Control register bit positions; all but the rung are one-shot operations.
	localparam int FPC_C_RUNG = 0;
	localparam int FPC_C_EVAL = 1;
	localparam int FPC_C_CLEAR = 2;
	localparam int FPC_C_LOAD = 3;
	localparam int FPC_C_IRQEN = 4;
	localparam int FPC_C_IRQDIS = 5;
	localparam int FPC_C_LDPRE = 6;
	localparam int FPC_C_ISR = 7;

	// Modes, limits and the error code for a rejected high preset.
	localparam logic [3:0] FPC_MODE_RST = 4'h1;
	localparam logic [3:0] FPC_MODE_UP_LAST = 4'h2;
	localparam logic signed [15:0] FPC_ACC_MAX = 16'sh7FFF;
	localparam logic signed [15:0] FPC_ACC_MIN = 16'sh8000;
	localparam logic signed [15:0] FPC_HP_MIN = 16'sh0001;
	localparam logic [7:0] FPC_ERR_CODE = 8'h37;

	// Configuration life cycle of the counter.
	typedef enum logic [0:0] {FPC_ST_UNCONF = 1'b0, FPC_ST_CONF = 1'b1} fpc_state_t;

	// Decoded count events from the input pins.
	typedef struct packed {
		logic up;
		logic down;
		logic zero;
		logic hold;
	} fpc_cnt_ev_t;

	// One-shot operations decoded from a control write.
	typedef struct packed {
		logic eval;
		logic rung;
		logic clear;
		logic load;
		logic irq_en;
		logic irq_dis;
		logic ld_pre;
		logic isr;
	} fpc_ops_t;

endpackage

// file: fpc_input.sv
/*
 Input stage of the fast pulse counter: synchronises the four counter pins and
 decodes them into count, reset and hold events for the selected mode.
 Assumes the pins are asynchronous to clk_i and slower than half its rate.
*/
`timescale 1ns/1ps
module fpc_input
	import fpc_pkg::*;
(
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic [3:0] pin_i, // Raw counter input pins.
	input wire logic [3:0] mode_i, // Counter mode, 1 to 8.
	output fpc_cnt_ev_t ev_o // Decoded events, pulses and hold level.
);

	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [3:0] prev_q;
	logic [3:0] rise;
	logic ext;

	////////////////////////////////////////////////////////////////////////////
	// Two flip-flops per pin, then a delayed copy for edge detection.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
			prev_q <= 4'h0;
		end
		else
		begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Rising edges of the synchronised pins.
	assign rise = sync_q & ~prev_q;
	// Even modes add the external reset and hold pins.
	assign ext = ~mode_i[0];

	////////////////////////////////////////////////////////////////////////////
	// Mode decode of count direction; the encoder counts once per A rise.
	always_comb
	begin
		ev_o = '0;
		ev_o.zero = ext & rise[2];
		ev_o.hold = ext & sync_q[3];
		case (mode_i)
			4'h1, 4'h2: ev_o.up = rise[0];
			4'h3, 4'h4:
			begin
				ev_o.up = rise[0] & ~sync_q[1];
				ev_o.down = rise[0] & sync_q[1];
			end
			4'h5, 4'h6:
			begin
				ev_o.up = rise[0] & ~rise[1];
				ev_o.down = rise[1] & ~rise[0];
			end
			4'h7, 4'h8:
			begin
				ev_o.up = rise[0] & ~sync_q[1];
				ev_o.down = rise[0] & sync_q[1];
			end
			default: ev_o = '0;
		endcase
	end

endmodule

// file: fpc_pin_model.sv
/*
 Model of the pulse source wired to the counter pins: makes clean count pulses
 on any one pin, each high level held for four clock cycles and each low level for at least four.
 Assumes the bench calls its task from a single process at a time.
*/
`timescale 1ns/1ps
module fpc_pin_model (
	input wire logic clk_i, // System clock.
	output logic [3:0] pin_o // Counter pins.
);

	////////////////////////////////////////////////////////////////////////
	// All pins rest low, so no stray edge appears between pulses.
	initial
	begin
		pin_o = 4'h0;
	end

	// Sends n pulses on one pin; four cycles per level beats the two-flop sync.
	task automatic pulse(input int ch, input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			pin_o[ch] <= 1'b1;
			repeat (4) @(posedge clk_i);
			pin_o[ch] <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask

endmodule

// file: tb_fast_pulse_counter_status.sv
/*
 Self-checking bench of the fast pulse counter: register calls over classic
 Wishbone with expected values, pulses from the pin model.
 Assumes the package constants and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_fast_pulse_counter_status
	import fpc_pkg::*;
;
	logic clk_i;
	logic rst_i;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [3:0] pin_i;
	logic [15:0] out_o;
	logic irq_o;
	int fails;
	int compares;

	////////////////////////////////////////////////////////////////////////
	// Design and the pulse source.
	fpc_top u_fpc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pin_i(pin_i), .out_o(out_o), .irq_o(irq_o));
	fpc_pin_model u_fpc_pin_model (.clk_i(clk_i), .pin_o(pin_i));

	// Clock of 20 ns.
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic test_done;
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle, held until ack; a missing ack counts as a mismatch.
	task automatic bus(input logic w, input logic [3:0] idx, input logic [15:0] d,
		input logic [3:0] s, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= s;
		wb_dat_i <= {16'h0000, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk_i);
		end
		if (n == 20)
			fails++;
		q = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Register write.
	task automatic wr(input logic [3:0] idx, input logic [15:0] d, input logic [3:0] s);
		logic [15:0] q;
		bus(1'b1, idx, d, s, q);
	endtask

	// Register read, compared under a mask.
	task automatic rd(input logic [3:0] idx, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] q;
		bus(1'b0, idx, 16'h0000, 4'hF, q);
		chk(q & m, e);
	endtask

	// Holds reset for sixteen cycles.
	task automatic hold_reset;
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog well beyond the expected run of a few hundred cycles.
	initial
	begin
		#200000;
		fails++;
		test_done();
	end

	// Up counter first, then a second reset and a bidirectional counter, then a third reset and an encoder.
	initial
	begin
		fails = 0;
		compares = 0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 6'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		hold_reset();
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'h0000);
		rd(FPC_IDX_MODE, 16'h000F, 16'h0001);
		wr(FPC_IDX_PRESET, 16'h0003, 4'h3);
		wr(FPC_IDX_SRC, 16'h00A5, 4'h3);
		wr(FPC_IDX_MASK, 16'h000F, 4'h3);
		wr(FPC_IDX_CTRL, 16'h0003, 4'h1);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'h8002);
		u_fpc_pin_model.pulse(0, 3);
		rd(FPC_IDX_HWACC, 16'hFFFF, 16'h0000);
		chk(out_o, 16'h0005);
		chk({15'h0000, irq_o}, 16'h0001);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'hA00A);
		wr(FPC_IDX_CTRL, 16'h0081, 4'h1);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'hA022);
		u_fpc_pin_model.pulse(0, 6);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'hB02E);
		wr(FPC_IDX_STATUS, 16'h0000, 4'h3);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'h802A);
		wr(FPC_IDX_CTRL, 16'h0005, 4'h1);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'h8022);
		rd(FPC_IDX_ACC, 16'hFFFF, 16'h0000);
		u_fpc_pin_model.pulse(0, 2);
		rd(FPC_IDX_HWACC, 16'hFFFF, 16'h0002);
		wr(FPC_IDX_STATUS, 16'h0400, 4'h2);
		rd(FPC_IDX_ACC, 16'hFFFF, 16'h0002);
		wr(FPC_IDX_ACC, 16'h0001, 4'h3);
		wr(FPC_IDX_CTRL, 16'h0009, 4'h1);
		rd(FPC_IDX_HWACC, 16'hFFFF, 16'h0001);
		wr(FPC_IDX_CTRL, 16'h0002, 4'h1);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'h0022);
		u_fpc_pin_model.pulse(0, 3);
		rd(FPC_IDX_HWACC, 16'hFFFF, 16'h0001);
		wr(FPC_IDX_CTRL, 16'h0021, 4'h1);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'h0020);
		wr(FPC_IDX_CTRL, 16'h0003, 4'h1);
		u_fpc_pin_model.pulse(0, 2);
		rd(FPC_IDX_STATUS, 16'hFFFF, 16'hA020);
		chk({15'h0000, irq_o}, 16'h0000);
		wr(FPC_IDX_CTRL, 16'h0011, 4'h1);
		rd(FPC_IDX_STATUS, 16'h0002, 16'h0002);
		wr(FPC_IDX_PRESET, 16'h0000, 4'h3);
		wr(FPC_IDX_CTRL, 16'h0041, 4'h1);
		rd(FPC_IDX_INFO, 16'hFFFF, 16'h8037);
		rd(4'hA, 16'hFFFF, 16'h0000);
		// Bidirectional up and down counter across both wrap points.
		hold_reset();
		wr(FPC_IDX_MODE, 16'h0005, 4'h3);
		wr(FPC_IDX_PRESET, 16'h0010, 4'h3);
		wr(FPC_IDX_LOWPRE, 16'hFFF0, 4'h3);
		wr(FPC_IDX_ACC, 16'h7FFF, 4'h3);
		wr(FPC_IDX_CTRL, 16'h0003, 4'h1);
		wr(FPC_IDX_CTRL, 16'h0081, 4'h1);
		rd(FPC_IDX_STATUS, 16'hC300, 16'hC200);
		u_fpc_pin_model.pulse(0, 1);
		wr(FPC_IDX_CTRL, 16'h0081, 4'h1);
		rd(FPC_IDX_STATUS, 16'hDBF8, 16'hD180);
		u_fpc_pin_model.pulse(1, 1);
		wr(FPC_IDX_CTRL, 16'h0081, 4'h1);
		rd(FPC_IDX_STATUS, 16'hDBF8, 16'hDA40);
		// Encoder with external reset: A rises with B low count up, a Z rise zeroes.
		hold_reset();
		wr(FPC_IDX_MODE, 16'h0008, 4'h3);
		wr(FPC_IDX_CTRL, 16'h0003, 4'h1);
		rd(FPC_IDX_STATUS, 16'hC000, 16'hC000);
		u_fpc_pin_model.pulse(0, 2);
		rd(FPC_IDX_HWACC, 16'hFFFF, 16'h0002);
		u_fpc_pin_model.pulse(2, 1);
		rd(FPC_IDX_HWACC, 16'hFFFF, 16'h0000);
		test_done();
	end

endmodule
